// File: verilog/edh_pkg.sv
// What this block does
// - Transfers start only on a recognised request
// - Handshake mode drives grant strobe for data
// - External mode uses address, strobes, selects, grant
// - External mode refuses SDRAM-side transfers
// - Paced mode never asserts the grant strobe
// - Paced mode follows ordinary master access sequencing
// - Interface release and re-drive follow the clock
// - Release during transitions and suspend pin
// - Suspend pin sampled on clock edges
// - Interface released before host grant goes low
// - Re-drive only after host grant returns high
// - Data enable switches on edges during accesses
// - Grant strobe changes only on clock edges
// - Write strobe leads grant on both edges
// - Read strobe leads grant, rises no later
// - Each wait state stretches grant by one cycle
// - Held request delays write completion
// - Held request prolongs read by whole cycles
package edh_pkg;

   // ----------------------------------------------------------------
   // Widths and counts
   // ----------------------------------------------------------------
   localparam int ADDR_W      = 24;   // External address width
   localparam int DATA_W      = 32;   // External data width
   localparam int SEL_W       = 4;    // Memory select count
   localparam int WAIT_W      = 3;    // Wait-state field width
   localparam int FIFO_DEPTH  = 8;    // Write data buffer depth
   localparam int PIN_CNT     = 4;    // Synchronised pin count

   // ----------------------------------------------------------------
   // Pin positions in the synchroniser vector
   // ----------------------------------------------------------------
   localparam int PIN_REQ     = 0;    // Transfer request, low active
   localparam int PIN_SUSPEND = 1;    // Suspend bus, low active
   localparam int PIN_HOST    = 2;    // Host request, low active
   localparam int PIN_ACK     = 3;    // Memory acknowledge

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [PIN_CNT-1:0] PIN_RESET  = 4'h7;      // Idle pins
   localparam logic [ADDR_W-1:0]  ADDR_RESET = 24'h000000;
   localparam logic [DATA_W-1:0]  DATA_RESET = 32'h00000000;
   localparam logic [SEL_W-1:0]   SEL_IDLE   = 4'hf;       // No select
   localparam logic [WAIT_W-1:0]  WAIT_RESET = 3'h0;

   // Handshake modes
   typedef enum logic [1:0]
   {
      EDH_MODE_HANDSHAKE = 2'h0,
      EDH_MODE_EXTERNAL  = 2'h1,
      EDH_MODE_PACED     = 2'h2
   } edh_mode_t;

   // Transfer sequencer states, Gray from ST_IDLE through ST_DONE
   typedef enum logic [2:0]
   {
      ST_IDLE    = 3'h0,
      ST_STROBE  = 3'h1,
      ST_GRANT   = 3'h3,
      ST_UNSTRB  = 3'h2,
      ST_DONE    = 3'h6
   } edh_state_t;

   // Channel setup held by the surrounding logic
   typedef struct packed
   {
      edh_mode_t           mode;          // Handshake mode
      logic                to_memory;     // 1: write to memory
      logic                target_sdram;  // Far side is SDRAM
      logic                sync_write;    // Use sync write select
      logic                boot_eprom;    // EPROM boot in progress
      logic [WAIT_W-1:0]   wait_states;   // Wait states of region
      logic [ADDR_W-1:0]   base;          // First word address
      logic [SEL_W-1:0]    select_n;      // Region select pattern
   } edh_cfg_t;

   // Memory interface pin values
   typedef struct packed
   {
      logic [ADDR_W-1:0]   addr;
      logic [SEL_W-1:0]    ms_n;
      logic                rd_n;
      logic                wr_n;
      logic                sw_n;
      logic                grant_n;
   } edh_bus_t;

   // Output enables, high while driving
   typedef struct packed
   {
      logic                addr_oe;       // Address and selects
      logic                strobe_oe;     // Read, write, sync, grant
      logic                data_oe;       // Data lines
      logic                boot_oe;       // Boot select
   } edh_drive_t;

   localparam edh_bus_t BUS_IDLE = '{ADDR_RESET, SEL_IDLE, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// File: verilog/edh_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// Small flip-flop FIFO with valid/ready on both sides
module edh_fifo
   import edh_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   output var  logic [WIDTH-1:0] out_data,
   output var  logic             out_valid,
   input  wire logic             out_ready
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];  // Word storage
   logic [PW-1:0]    wr_ptr;         // Next slot to fill
   logic [PW-1:0]    rd_ptr;         // Next slot to drain
   logic [PW:0]      count;          // Words held
   logic [PW:0]      next_count;     // Level after this edge
   logic             push;
   logic             pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign next_count = (PW+1)'(count + push - pop);
   assign out_valid = (count != '0);
   assign out_data  = store[rd_ptr];

   // Storage write
   always_ff @(posedge mclk)
   begin
      if (push)
      begin
         store[wr_ptr] <= in_data;
      end
   end

   // Ready from a flop, so the fill side never sees a combinational path
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         in_ready <= 1'b1;
      end
      else
      begin
         in_ready <= (next_count != (PW+1)'(DEPTH));
      end
   end

   // Pointers and fill level
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= PW'(wr_ptr + 1'b1);
         end
         if (pop)
         begin
            rd_ptr <= PW'(rd_ptr + 1'b1);
         end
         count <= next_count;
      end
   end

endmodule

`default_nettype wire

// File: verilog/edh_top.sv
`timescale 1ns/1ps
`default_nettype none

// External port handshake transfer engine with bus release
module edh_top
   import edh_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire edh_cfg_t          cfg,
   input  wire logic              addr_restart,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_valid,
   output var  logic              wr_ready,
   input  wire logic              xfer_request_n,
   input  wire logic              suspend_bus_tristate_n,
   input  wire logic              host_request_n,
   input  wire logic              master_transition_cycle,
   input  wire logic              host_transition_cycle,
   input  wire logic              ack,
   input  wire logic [DATA_W-1:0] data_in,
   output var  edh_bus_t          bus,
   output var  edh_drive_t        drive,
   output var  logic [DATA_W-1:0] data_out,
   output var  logic              boot_memory_select_n,
   output var  logic              host_grant_n,
   output var  logic [DATA_W-1:0] rd_data,
   output var  logic              rd_valid,
   output var  logic              refused,
   output var  logic              busy
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [PIN_CNT-1:0] sync1;        // First stage, read by sync2 only
   logic [PIN_CNT-1:0] sync2;        // Second stage
   logic [PIN_CNT-1:0] sync3;        // Third stage
   logic [PIN_CNT-1:0] pin_level;    // Filtered pin levels
   logic [PIN_CNT-1:0] pin_raw;      // Pins gathered
   logic [PIN_CNT-1:0] pin_agree;    // Second and third stage agree
   logic               req_low;      // Request recognised
   logic               req_armed;    // Request seen high since last word
   logic               release_req;  // Transition or suspend active
   logic               host_hold;    // Host owns or is taking the bus
   logic               bus_live;     // Interface currently driven
   logic               start_ok;     // Request may be acted on
   logic               sdram_block;  // External mode to SDRAM
   logic               grant_used;   // Mode uses the grant strobe
   edh_state_t         state;        // Sequencer state
   edh_state_t         next_state;   // Sequencer next state
   logic [WAIT_W-1:0]  wait_cnt;     // Wait states still to run
   logic [ADDR_W-1:0]  offset;       // Words done since restart
   logic [DATA_W-1:0]  fifo_data;    // Head of write buffer
   logic               fifo_valid;   // Write buffer not empty
   logic               fifo_pop;     // Take one word
   edh_bus_t           next_bus;     // Next interface pin values
   edh_drive_t         next_drive;   // Next output enables
   logic [WAIT_W:0]    grant_len;    // Helper: cycles spent in grant

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   assign pin_raw   = {ack, host_request_n, suspend_bus_tristate_n, xfer_request_n};
   assign pin_agree = ~(sync2 ^ sync3);

   // Three stages, a change counts once stages two and three agree
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sync1     <= PIN_RESET;
         sync2     <= PIN_RESET;
         sync3     <= PIN_RESET;
         pin_level <= PIN_RESET;
      end
      else
      begin
         sync1     <= pin_raw;
         sync2     <= sync1;
         sync3     <= sync2;
         pin_level <= (sync3 & pin_agree) | (pin_level & ~pin_agree);
      end
   end

   assign req_low     = ~pin_level[PIN_REQ];
   assign release_req = master_transition_cycle | host_transition_cycle
                      | ~pin_level[PIN_SUSPEND];
   assign bus_live    = drive.addr_oe;
   assign sdram_block = (cfg.mode == EDH_MODE_EXTERNAL) && cfg.target_sdram;
   assign grant_used  = (cfg.mode != EDH_MODE_PACED);
   assign start_ok    = req_low && req_armed && !release_req && !host_hold && bus_live;

   // ----------------------------------------------------------------
   // Write data buffer
   // ----------------------------------------------------------------
   edh_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .rst       (rst),
      .in_data   (wr_data),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );

   // Pop one word as a write transfer is accepted
   assign fifo_pop = (state == ST_IDLE) && start_ok && !sdram_block
                   && cfg.to_memory && fifo_valid;

   // ----------------------------------------------------------------
   // Request arming
   // ----------------------------------------------------------------
   // Armed by a high request, used up by one word or a refusal
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         req_armed <= 1'b1;
      end
      else if (!req_low)
      begin
         req_armed <= 1'b1;
      end
      else if (state == ST_IDLE && next_state == ST_STROBE)
      begin
         req_armed <= 1'b0;
      end
      else if (state == ST_IDLE && start_ok && sdram_block)
      begin
         req_armed <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Transfer sequencer
   // ----------------------------------------------------------------
   // Next state; frozen while the interface is released
   always_comb
   begin
      next_state = state;
      if (bus_live && !release_req)
      begin
         unique case (state)
            ST_IDLE:
            begin
               // Writes also need a buffered word
               if (start_ok && !sdram_block && (!cfg.to_memory || fifo_valid))
               begin
                  next_state = ST_STROBE;
               end
            end
            ST_STROBE:
            begin
               next_state = ST_GRANT;
            end
            ST_GRANT:
            begin
               // Wait states, held request, then acknowledge outside handshake mode
               if (wait_cnt != '0)
               begin
                  next_state = ST_GRANT;
               end
               else if (req_low)
               begin
                  next_state = ST_GRANT;
               end
               else if (cfg.mode != EDH_MODE_HANDSHAKE && !pin_level[PIN_ACK])
               begin
                  next_state = ST_GRANT;
               end
               else
               begin
                  next_state = ST_UNSTRB;
               end
            end
            ST_UNSTRB:
            begin
               next_state = ST_DONE;
            end
            ST_DONE:
            begin
               next_state = ST_IDLE;
            end
            default:
            begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state <= ST_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Wait-state counter loaded as the grant opens
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wait_cnt <= WAIT_RESET;
      end
      else if (next_state == ST_GRANT && state == ST_STROBE)
      begin
         wait_cnt <= cfg.wait_states;
      end
      else if (state == ST_GRANT && next_state == ST_GRANT && wait_cnt != '0)
      begin
         wait_cnt <= WAIT_W'(wait_cnt - 1'b1);
      end
   end

   // Word address offset
   always_ff @(posedge mclk)
   begin
      if (rst || addr_restart)
      begin
         offset <= ADDR_RESET;
      end
      else if (state == ST_DONE && next_state == ST_IDLE)
      begin
         offset <= ADDR_W'(offset + 1'b1);
      end
   end

   // ----------------------------------------------------------------
   // Interface pin values
   // ----------------------------------------------------------------
   // Strobes lead the grant by one cycle on both edges
   always_comb
   begin
      next_bus = BUS_IDLE;
      if (next_state != ST_IDLE)
      begin
         next_bus.addr = ADDR_W'(cfg.base + offset);
         next_bus.ms_n = cfg.select_n;
         next_bus.sw_n = ~(cfg.mode == EDH_MODE_EXTERNAL && cfg.sync_write);
      end
      if (next_state == ST_STROBE || next_state == ST_GRANT)
      begin
         next_bus.wr_n = ~cfg.to_memory;
         next_bus.rd_n = cfg.to_memory;
      end
      if (next_state == ST_GRANT || next_state == ST_UNSTRB)
      begin
         next_bus.grant_n = ~grant_used;
      end
   end

   // Enables drop while released, data only during writes
   always_comb
   begin
      next_drive.addr_oe   = !(release_req || host_hold);
      next_drive.strobe_oe = next_drive.addr_oe;
      next_drive.data_oe   = next_drive.addr_oe && cfg.to_memory
                           && next_state != ST_IDLE;
      next_drive.boot_oe   = next_drive.addr_oe && cfg.boot_eprom;
   end

   // Registered pins, all on clock edges
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         bus   <= BUS_IDLE;
         drive <= '0;
      end
      else
      begin
         bus   <= next_bus;
         drive <= next_drive;
      end
   end

   // Write data latched from the buffer head
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         data_out <= DATA_RESET;
      end
      else if (fifo_pop)
      begin
         data_out <= fifo_data;
      end
   end

   // Boot select stays inactive, driven only in EPROM boot
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         boot_memory_select_n <= 1'b1;
      end
      else
      begin
         boot_memory_select_n <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Host bus ownership
   // ----------------------------------------------------------------
   // Host takes the bus between words, gives it back on request high
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         host_hold <= 1'b0;
      end
      else if (!pin_level[PIN_HOST] && state == ST_IDLE && next_state == ST_IDLE)
      begin
         host_hold <= 1'b1;
      end
      else if (pin_level[PIN_HOST] && host_grant_n)
      begin
         host_hold <= 1'b0;
      end
   end

   // Grant low only once the interface already stands released
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         host_grant_n <= 1'b1;
      end
      else if (pin_level[PIN_HOST])
      begin
         host_grant_n <= 1'b1;
      end
      else if (host_hold && !drive.addr_oe)
      begin
         host_grant_n <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read data and status
   // ----------------------------------------------------------------
   // Read word taken while the read strobe is still low
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rd_data  <= DATA_RESET;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= 1'b0;
         if (state == ST_GRANT && next_state == ST_UNSTRB && !cfg.to_memory)
         begin
            rd_data  <= data_in;
            rd_valid <= 1'b1;
         end
      end
   end

   // Refusal pulse and busy level
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         refused <= 1'b0;
         busy    <= 1'b0;
      end
      else
      begin
         refused <= (state == ST_IDLE) && start_ok && sdram_block;
         busy    <= (next_state != ST_IDLE);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // Helper: grant cycle count
   always_ff @(posedge mclk)
   begin
      if (rst || state != ST_GRANT)
      begin
         grant_len <= '0;
      end
      else if (grant_len != '1)
      begin
         grant_len <= (WAIT_W+1)'(grant_len + 1'b1);
      end
   end

   sequence s_word_start;
      state == ST_IDLE ##1 state == ST_STROBE;
   endsequence

   sequence s_grant_exit;
      state == ST_GRANT && next_state == ST_UNSTRB;
   endsequence

   chk_start_on_req: assert property (s_word_start |-> $past(req_low) && $past(req_armed))
      else $error("word started without a request");
   chk_sdram_refused: assert property ((state == ST_IDLE && start_ok && sdram_block)
      |=> refused && state == ST_IDLE)
      else $error("external transfer to sdram not refused");
   chk_paced_no_grant: assert property ((state != ST_IDLE && cfg.mode == EDH_MODE_PACED) |-> bus.grant_n)
      else $error("grant asserted in paced mode");
   chk_strobe_leads_grant: assert property ($fell(bus.grant_n) |-> $past(!bus.wr_n || !bus.rd_n))
      else $error("grant fell without a leading strobe");
   chk_strobe_rise_first: assert property ($rose(bus.grant_n) |-> $past(bus.wr_n && bus.rd_n))
      else $error("strobe still low when grant rose");
   chk_wait_stretch: assert property (s_grant_exit |-> grant_len >= (WAIT_W+1)'(cfg.wait_states))
      else $error("grant shorter than wait states");
   chk_one_word_req: assert property ((state == ST_IDLE && !req_armed) |=> state != ST_STROBE)
      else $error("second word from one request");
   chk_release_follows: assert property (release_req |=> !drive.addr_oe && !drive.strobe_oe)
      else $error("interface still driven during release");
   chk_release_before_hbg: assert property ($fell(host_grant_n) |-> !drive.addr_oe ##1 !drive.addr_oe)
      else $error("host grant low while interface driven");
   chk_redrive_after_hbg: assert property ($rose(drive.addr_oe) |-> host_grant_n && $past(host_grant_n, 2))
      else $error("interface re-driven before host grant high");

endmodule

`default_nettype wire

// File: testbench/edh_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Memory side: ack after a lag, read word from address
// ------------------------------
module edh_peer
   import edh_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire edh_bus_t          bus,
   input  wire edh_drive_t        drive,
   input  wire logic [1:0]        lag,
   output var  logic              ack,
   output var  logic [DATA_W-1:0] data_in
);
   logic [1:0] cnt;  // Cycles since strobe fell
   logic       act;  // Strobe driven and low
   assign act = drive.strobe_oe && !(bus.rd_n && bus.wr_n);
   // Lag counter, cleared when strobes rise
   always_ff @(posedge mclk)
   begin
      if (rst || !act)
         cnt <= 2'h0;
      else if (cnt != lag)
         cnt <= cnt + 2'h1;
   end
   assign ack = act && (cnt == lag);
   // Lines flip each cycle when not answering a read
   always_ff @(posedge mclk)
   begin
      if (rst)
         data_in <= 32'h0;
      else if (act && !bus.rd_n)
         data_in <= {8'h00, bus.addr};
      else
         data_in <= ~data_in;
   end
endmodule
`default_nettype wire

// File: testbench/edh_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module edh_top_tb import edh_pkg::*;;
   logic mclk = 0, rst = 1, addr_restart = 0, wr_valid = 0, xfer_request_n = 1, host_request_n = 1;
   logic suspend_bus_tristate_n = 1, master_transition_cycle = 0, host_transition_cycle = 0;
   logic ack, wr_ready, boot_memory_select_n, host_grant_n, rd_valid, refused, busy, ph, g;
   logic [DATA_W-1:0] wr_data = 0, data_in, data_out, rd_data;
   logic [1:0] lag = 0;
   edh_cfg_t cfg = '0;
   edh_bus_t bus;
   edh_drive_t drive, pd;
   int n_fail = 0, tests_run = 0, off = 0;
   edh_top u_edh_top (.mclk, .rst, .cfg, .addr_restart, .wr_data, .wr_valid, .wr_ready, .xfer_request_n,
      .suspend_bus_tristate_n, .host_request_n, .master_transition_cycle, .host_transition_cycle, .ack,
      .data_in, .bus, .drive, .data_out, .boot_memory_select_n, .host_grant_n, .rd_data, .rd_valid,
      .refused, .busy);
   edh_peer u_edh_peer (.mclk, .rst, .bus, .drive, .lag, .ack, .data_in);
   always #50 mclk = ~mclk;
   // Compare and count
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One requested word, watched for 40 cycles
   task automatic word(edh_mode_t m, logic w, logic sd, int hold);
      int ws = $urandom_range(0, 3);
      logic [23:0] b = $urandom;
      logic [31:0] d = $urandom;
      int gl = 0, sl = 0, gf = 0, u = 0;
      logic s, pg = 1, rf = 0;
      @(posedge mclk);
      cfg <= '{m, w, sd, 1'b1, b[0], ws[2:0], b, 4'he};
      wr_data <= d;
      wr_valid <= w;
      lag <= 2'($urandom);
      xfer_request_n <= 1'b0;
      @(posedge mclk);
      wr_valid <= 1'b0;
      repeat (40)
      begin
         @(negedge mclk);
         s = !(w ? bus.wr_n : bus.rd_n);
         if (!bus.grant_n && gl == 0) chk("strobe lead", 1, s);
         if (s) chk("address", 24'(b + 24'(off)), bus.addr);
         if (s) chk("select", 4'he, bus.ms_n);
         if (s) chk("sync select", m != EDH_MODE_EXTERNAL, bus.sw_n);
         if (s) chk("data drive", w, drive.data_oe);
         if (drive.addr_oe) chk("boot drive", b[0], drive.boot_oe);
         if (rd_valid) chk("read word", {8'h00, 24'(b + 24'(off))}, rd_data);
         if (s && w) chk("write word", d, data_out);
         gf += (!bus.grant_n && pg);
         u += (!bus.grant_n && !s);
         gl += !bus.grant_n;
         sl += s;
         rf |= refused;
         pg = bus.grant_n;
         @(posedge mclk);
         if (s && sl > hold) xfer_request_n <= 1'b1;
      end
      chk("refused", sd, rf);
      chk("transfer", !sd, sl > 0);
      chk("grant pulses", (m == EDH_MODE_PACED || sd) ? 0 : 1, gf);
      if (gf == 1) chk("grant width", 1, gl >= ws + 2);
      if (gf == 1 && w) chk("strobe trail", 1, u > 0);
      off += !sd;
      xfer_request_n <= 1'b1;
      repeat (4) @(posedge mclk);
      $display("word mode %0d write %0d done", m, w);
   endtask
   initial
   begin
      void'($urandom(52049));
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      addr_restart <= 1'b1;
      @(posedge mclk);
      addr_restart <= 1'b0;
      repeat (10) @(negedge mclk);
      chk("idle busy", 0, busy);
      chk("buffer ready", 1, wr_ready);
      chk("boot select", 1, boot_memory_select_n);
      for (int i = 0; i < 24; i++)
         word(edh_mode_t'(i % 3), i[1], 1'b0, $urandom_range(0, 4));
      word(EDH_MODE_EXTERNAL, 1'b0, 1'b1, 0);
      // Suspend pin, then each transition cycle
      for (int i = 0; i < 3; i++)
      begin
         @(posedge mclk);
         suspend_bus_tristate_n <= (i != 0);
         master_transition_cycle <= (i == 1);
         host_transition_cycle <= (i == 2);
         repeat (6) @(negedge mclk);
         chk("released", 0, drive);
         @(posedge mclk);
         suspend_bus_tristate_n <= 1'b1;
         master_transition_cycle <= 1'b0;
         host_transition_cycle <= 1'b0;
         repeat (6) @(negedge mclk);
         chk("redriven", 2'h3, {drive.addr_oe, drive.strobe_oe});
      end
      $display("release test done");
      // Host takes the bus, then hands it back
      g = 0;
      pd = drive;
      ph = host_grant_n;
      for (int i = 0; i < 24; i++)
      begin
         @(posedge mclk);
         host_request_n <= (i >= 11);
         @(negedge mclk);
         if (!host_grant_n) chk("hold order", 0, pd);
         if (drive.addr_oe) chk("resume order", 1, ph);
         pd = drive;
         ph = host_grant_n;
         g |= !host_grant_n;
      end
      chk("host grant seen", 1, g);
      chk("host grant back", 1, host_grant_n);
      $display("host test done");
      stop_test();
   end
   // Watchdog
   initial
   begin
      #400000;
      n_fail++;
      $display("watchdog expired");
      stop_test();
   end
endmodule
`default_nettype wire
